// ### bench/ccsb_unit_bench.sv
// Self-checking bench for the control-flow unit.
`timescale 1ns/100ps
module ccsb_unit_bench;
  logic        ref_clk;
  logic        reset_n;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic [15:0] instr_ext;
  logic        next_is_two_word;
  logic [15:0] z_pointer;
  logic        instr_ready;
  logic        instr_done;
  logic [4:0]  rd_sel;
  logic [4:0]  rr_sel;
  logic [4:0]  io_addr;
  logic [15:0] pc;
  logic [7:0]  status_flags_register;
  logic [3:0]  stack_depth;
  int          n_mismatch;
  int          checks;

  ccsb_unit ccsb_unit_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ext(instr_ext), .next_is_two_word(next_is_two_word), .instr_ready(instr_ready),
    .instr_done(instr_done), .rd_sel(rd_sel), .rr_sel(rr_sel), .rd_data({3'h0, rd_sel}),
    .rr_data({3'h0, rr_sel}), .io_addr(io_addr), .io_data({3'h0, io_addr}),
    .z_pointer(z_pointer), .pc(pc), .status_flags_register(status_flags_register),
    .stack_depth(stack_depth)
  );

  always #10 ref_clk = ~ref_clk;

  task complete_run;
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Issues one instruction and counts edges from the taking edge to retirement.
  task automatic ex(input logic [15:0] w, input logic [15:0] e, input logic two,
                    input int cyc, input logic [15:0] epc, input logic [7:0] efl,
                    input logic [3:0] edep);
    int n;
    @(posedge ref_clk);
    instr_valid      <= 1'b1;
    instr_word       <= w;
    instr_ext        <= e;
    next_is_two_word <= two;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    n = 1;
    while (instr_done !== 1'b1 && n < 8)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    checks++;
    if (n != cyc || pc !== epc || status_flags_register !== efl || stack_depth !== edep)
    begin
      n_mismatch++;
      $display("unexpected at %0t: word %h gave pc %h after %0d cycles", $time, w, pc, n);
    end
  endtask

  initial
  begin
    #50000;
    n_mismatch++;
    complete_run;
  end

  // Register file and I/O space read back their own index.
  initial
  begin
    ref_clk          = 1'b0;
    reset_n          = 1'b0;
    instr_valid      = 1'b0;
    instr_word       = 16'h0000;
    instr_ext        = 16'h0000;
    next_is_two_word = 1'b0;
    z_pointer        = 16'h0200;
    n_mismatch       = 0;
    checks           = 0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    checks++;
    if (pc !== 16'h0000 || status_flags_register !== 8'h00 || stack_depth !== 4'h0 ||
        instr_ready !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: state after reset", $time);
    end
    ex(16'h1412, 16'h0000, 1'b0, 1, 16'h0001, 8'h25, 4'h0);
    ex(16'h3900, 16'h0000, 1'b0, 1, 16'h0002, 8'h0d, 4'h0);
    ex(16'h0422, 16'h0000, 1'b0, 1, 16'h0003, 8'h25, 4'h0);
    ex(16'h3100, 16'h0000, 1'b0, 1, 16'h0004, 8'h02, 4'h0);
    ex(16'h0433, 16'h0000, 1'b0, 1, 16'h0005, 8'h02, 4'h0);
    ex(16'hf029, 16'h0000, 1'b0, 2, 16'h000b, 8'h02, 4'h0);
    ex(16'hf429, 16'h0000, 1'b0, 1, 16'h000c, 8'h02, 4'h0);
    ex(16'hf028, 16'h0000, 1'b0, 1, 16'h000d, 8'h02, 4'h0);
    ex(16'hf7f0, 16'h0000, 1'b0, 2, 16'h000c, 8'h02, 4'h0);
    ex(16'h1044, 16'h0000, 1'b0, 2, 16'h000e, 8'h02, 4'h0);
    ex(16'h1045, 16'h0000, 1'b0, 1, 16'h000f, 8'h02, 4'h0);
    ex(16'hfc51, 16'h0000, 1'b1, 3, 16'h0012, 8'h02, 4'h0);
    ex(16'hfe50, 16'h0000, 1'b0, 2, 16'h0014, 8'h02, 4'h0);
    ex(16'hfe51, 16'h0000, 1'b0, 1, 16'h0015, 8'h02, 4'h0);
    ex(16'h9930, 16'h0000, 1'b0, 2, 16'h0017, 8'h02, 4'h0);
    ex(16'h9b31, 16'h0000, 1'b1, 3, 16'h001a, 8'h02, 4'h0);
    ex(16'h9931, 16'h0000, 1'b0, 1, 16'h001b, 8'h02, 4'h0);
    ex(16'hd010, 16'h0000, 1'b0, 3, 16'h002c, 8'h02, 4'h1);
    ex(16'h9509, 16'h0000, 1'b0, 3, 16'h0200, 8'h02, 4'h2);
    ex(16'h940e, 16'h0400, 1'b0, 4, 16'h0400, 8'h02, 4'h3);
    ex(16'h9508, 16'h0000, 1'b0, 4, 16'h0202, 8'h02, 4'h2);
    ex(16'h9518, 16'h0000, 1'b0, 4, 16'h002d, 8'h82, 4'h1);
    ex(16'h9508, 16'h0000, 1'b0, 4, 16'h001c, 8'h82, 4'h0);
    ex(16'h1412, 16'h0000, 1'b0, 1, 16'h001d, 8'ha5, 4'h0);
    ex(16'hf409, 16'h0000, 1'b0, 2, 16'h001f, 8'ha5, 4'h0);
    ex(16'hf009, 16'h0000, 1'b0, 1, 16'h0020, 8'ha5, 4'h0);
    complete_run;
  end
endmodule

// ### bench/ccsb_unit_checker.sv
// Concurrent checks on the control-flow unit's ports.
`timescale 1ns/100ps
module ccsb_unit_checker
  import ccsb_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Instruction port
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] instr_ext,
  input wire logic        next_is_two_word,
  input wire logic        instr_ready,
  input wire logic        instr_done,
  // Operand sources
  input wire logic [7:0]  rd_data,
  input wire logic [7:0]  rr_data,
  input wire logic [7:0]  io_data,
  input wire logic [15:0] z_pointer,
  // Core state
  input wire logic [15:0] pc,
  input wire logic [7:0]  status_flags_register,
  input wire logic [3:0]  stack_depth
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic take;
  logic br_hit;
  assign take   = instr_valid && instr_ready;
  assign br_hit = status_flags_register[instr_word[2:0]] ^ instr_word[10];
  property p_relcall;
    take && (instr_word & OP_RELCALL_MASK) == OP_RELCALL |=> !instr_done[*2] ##1 (instr_done &&
      pc == 16'($past(pc, 3) + {{4{$past(instr_word[11], 3)}}, $past(instr_word[11:0], 3)} + 1));
  endproperty
  a_relcall: assert property (p_relcall) else $error("relative call wrong");
  property p_indcall;
    take && instr_word == OP_INDCALL |=> $stable(status_flags_register) ##0 !instr_done[*2] ##1
      (instr_done && pc == $past(z_pointer, 3));
  endproperty
  a_indcall: assert property (p_indcall) else $error("indirect call wrong");
  property p_call;
    take && (instr_word & OP_CALL_MASK) == OP_CALL |=> !instr_done[*3] ##1
      (instr_done && pc == $past(instr_ext, 4));
  endproperty
  a_call: assert property (p_call) else $error("direct call wrong");
  property p_subexit;
    take && instr_word == OP_SUBEXIT |=> (stack_depth == 4'($past(stack_depth) - 4'h1) &&
      $stable(status_flags_register)) ##3 instr_done;
  endproperty
  a_subexit: assert property (p_subexit) else $error("return wrong");
  property p_intexit;
    take && instr_word == OP_INTEXIT |=> !instr_done[*3] ##1
      (instr_done && status_flags_register[FLAG_I]);
  endproperty
  a_intexit: assert property (p_intexit) else $error("interrupt return wrong");
  property p_eqskip;
    take && (instr_word & OP_CMP_MASK) == OP_EQSKIP && rd_data == rr_data && !next_is_two_word
      |=> !instr_done ##1 (instr_done && pc == 16'($past(pc, 2) + 2));
  endproperty
  a_eqskip: assert property (p_eqskip) else $error("equal skip wrong");
  property p_cmp;
    take && ((instr_word & OP_CMP_MASK) == OP_REGCMP ||
      (instr_word & OP_IMMCMP_MASK) == OP_IMMCMP) |=> instr_done && pc == 16'($past(pc) + 1) &&
      (status_flags_register & 8'hd0) == ($past(status_flags_register) & 8'hd0);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrong");
  property p_iobit_skip;
    take && (instr_word & OP_IOBIT_MASK) == OP_IOBIT_SET && io_data[instr_word[2:0]] &&
      next_is_two_word |=> !instr_done[*2] ##1 (instr_done && pc == 16'($past(pc, 3) + 3));
  endproperty
  a_iobit_skip: assert property (p_iobit_skip) else $error("two-word skip wrong");
  property p_branch;
    take && (instr_word & 16'hf800) == 16'hf000 && br_hit |=> !instr_done ##1 (instr_done &&
      pc == 16'($past(pc, 2) + {{9{$past(instr_word[9], 2)}}, $past(instr_word[9:3], 2)} + 1));
  endproperty
  a_branch: assert property (p_branch) else $error("taken branch wrong");
  property p_branch_miss;
    take && (instr_word & 16'hf800) == 16'hf000 && !br_hit |=>
      instr_done && pc == 16'($past(pc) + 1);
  endproperty
  a_branch_miss: assert property (p_branch_miss) else $error("untaken branch wrong");
  property p_push;
    take && ((instr_word & OP_RELCALL_MASK) == OP_RELCALL || instr_word == OP_INDCALL ||
      (instr_word & OP_CALL_MASK) == OP_CALL) |=> stack_depth == 4'($past(stack_depth) + 4'h1);
  endproperty
  a_push: assert property (p_push) else $error("call did not push");
endmodule

bind ccsb_unit ccsb_unit_checker ccsb_unit_checker_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ext(instr_ext), .next_is_two_word(next_is_two_word), .instr_ready(instr_ready),
  .instr_done(instr_done), .rd_data(rd_data), .rr_data(rr_data), .io_data(io_data),
  .z_pointer(z_pointer), .pc(pc), .status_flags_register(status_flags_register),
  .stack_depth(stack_depth)
);

// ### src/ccsb_cmp_flags.sv
// Subtract-and-flag logic shared by all compare forms.
`timescale 1ns/100ps
module ccsb_cmp_flags
  import ccsb_pkg::*;
(
  // Operands
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  input  wire logic       use_carry,
  input  wire logic       carry_in,
  input  wire logic       zero_in,
  // Flags
  output logic            flag_h,
  output logic            flag_v,
  output logic            flag_n,
  output logic            flag_z,
  output logic            flag_c
);
  logic [7:0] diff;
  logic       borrow;

  always_comb
  begin
    borrow = use_carry & carry_in;
    diff   = op_a - op_b - {7'h00, borrow};
    flag_h = (~op_a[3] & op_b[3]) | (op_b[3] & diff[3]) | (diff[3] & ~op_a[3]);
    flag_v = (op_a[7] & ~op_b[7] & ~diff[7]) | (~op_a[7] & op_b[7] & diff[7]);
    flag_n = diff[7];
    flag_c = (~op_a[7] & op_b[7]) | (op_b[7] & diff[7]) | (diff[7] & ~op_a[7]);
    // With carry in, a zero result only keeps Z, so multi-byte compares chain.
    flag_z = (diff == 8'h00) & (use_carry ? zero_in : 1'b1);
  end
endmodule

// ### src/ccsb_pkg.sv
// Package with opcode patterns, flag positions and cycle counts for the control-flow unit.
// Notes on behaviour
// - Relative call: pc plus offset plus one, 3 cycles.
// - Indirect call: pc from Z, flags kept, 3 cycles.
// - Direct call: pc from absolute word, 4 cycles.
// - Return: pc from stack, flags kept, 4 cycles.
// - Interrupt return: pc from stack, set I, 4 cycles.
// - Equal compare skips next instruction, flags kept.
// - Compares set Z N V C H only, 1 cycle.
// - Skip when register bit is clear.
// - Skip when register bit is set.
// - Skip when I/O bit is clear.
// - Skip when I/O bit is set.
// - Branch when selected flag set, 1 or 2 cycles.
// - Branch when selected flag clear, 1 or 2 cycles.
// - Zero and nonzero branches test Z, 1 or 2.
package ccsb_pkg;
  localparam logic [15:0] OP_RELCALL_MASK = 16'hf000;
  localparam logic [15:0] OP_RELCALL      = 16'hd000;
  localparam logic [15:0] OP_INDCALL      = 16'h9509;
  localparam logic [15:0] OP_CALL_MASK    = 16'hfe0e;
  localparam logic [15:0] OP_CALL         = 16'h940e;
  localparam logic [15:0] OP_SUBEXIT      = 16'h9508;
  localparam logic [15:0] OP_INTEXIT      = 16'h9518;
  localparam logic [15:0] OP_CMP_MASK     = 16'hfc00;
  localparam logic [15:0] OP_EQSKIP       = 16'h1000;
  localparam logic [15:0] OP_REGCMP       = 16'h1400;
  localparam logic [15:0] OP_CARRYCMP     = 16'h0400;
  localparam logic [15:0] OP_IMMCMP_MASK  = 16'hf000;
  localparam logic [15:0] OP_IMMCMP       = 16'h3000;
  localparam logic [15:0] OP_REGBIT_MASK  = 16'hfe08;
  localparam logic [15:0] OP_REGBIT_CLR   = 16'hfc00;
  localparam logic [15:0] OP_REGBIT_SET   = 16'hfe00;
  localparam logic [15:0] OP_IOBIT_MASK   = 16'hff00;
  localparam logic [15:0] OP_IOBIT_CLR    = 16'h9900;
  localparam logic [15:0] OP_IOBIT_SET    = 16'h9b00;
  localparam logic [15:0] OP_FLAGBR_MASK  = 16'hfc00;
  localparam logic [15:0] OP_FLAGBR_SET   = 16'hf000;
  localparam logic [15:0] OP_FLAGBR_CLR   = 16'hf400;
  localparam int          FLAG_C          = 0;
  localparam int          FLAG_Z          = 1;
  localparam int          FLAG_N          = 2;
  localparam int          FLAG_V          = 3;
  localparam int          FLAG_H          = 5;
  localparam int          FLAG_I          = 7;
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [3:0]  SP_RESET        = 4'h0;
  localparam int          STACK_DEPTH     = 16;
  localparam logic [2:0]  CYC_RELCALL     = 3'd3;
  localparam logic [2:0]  CYC_INDCALL     = 3'd3;
  localparam logic [2:0]  CYC_CALL        = 3'd4;
  localparam logic [2:0]  CYC_EXIT        = 3'd4;
  localparam logic [2:0]  CYC_ONE         = 3'd1;
  localparam logic [2:0]  CYC_TWO         = 3'd2;
  localparam logic [2:0]  CYC_THREE       = 3'd3;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } ccsb_state_t;
endpackage

// ### src/ccsb_unit.sv
// Control-flow unit: calls, returns, compares, skips and conditional branches.
`timescale 1ns/100ps
module ccsb_unit
  import ccsb_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Instruction stream
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [15:0] instr_ext,
  input  wire logic        next_is_two_word,
  output logic             instr_ready,
  output logic             instr_done,
  // Register file and I/O read ports
  output logic [4:0]       rd_sel,
  output logic [4:0]       rr_sel,
  input  wire logic [7:0]  rd_data,
  input  wire logic [7:0]  rr_data,
  output logic [4:0]       io_addr,
  input  wire logic [7:0]  io_data,
  input  wire logic [15:0] z_pointer,
  // Core state
  output logic [15:0]      pc,
  output logic [7:0]       status_flags_register,
  output logic [3:0]       stack_depth
);
  ccsb_state_t state_r;
  logic [15:0] pc_r;
  logic [15:0] tgt_r;
  logic [2:0]  cnt_r;
  logic [7:0]  flags_r;
  logic [3:0]  sp_r;
  logic [15:0] stack_mem [STACK_DEPTH];
  logic        done_r;

  logic        accept;
  logic        is_relcall;
  logic        is_indcall;
  logic        is_call;
  logic        is_subexit;
  logic        is_intexit;
  logic        is_eqskip;
  logic        is_regcmp;
  logic        is_carrycmp;
  logic        is_immcmp;
  logic        is_regbit_clr;
  logic        is_regbit_set;
  logic        is_iobit_clr;
  logic        is_iobit_set;
  logic        is_flagbr_set;
  logic        is_flagbr_clr;
  logic        is_cmp;
  logic        skip_hit;
  logic        br_hit;
  logic [15:0] rel12;
  logic [15:0] rel7;
  logic [15:0] pc_plus1;
  logic [15:0] target;
  logic [2:0]  cycles;
  logic        do_push;
  logic [15:0] push_val;
  logic        do_pop;
  logic [15:0] pop_val;
  logic [7:0]  cmp_b;
  logic        f_h;
  logic        f_v;
  logic        f_n;
  logic        f_z;
  logic        f_c;

  assign accept      = instr_valid & (state_r == ST_IDLE);
  assign instr_ready = (state_r == ST_IDLE);
  assign instr_done  = done_r;
  assign pc          = pc_r;
  assign status_flags_register = flags_r;
  assign stack_depth = sp_r;

  assign is_relcall    = (instr_word & OP_RELCALL_MASK) == OP_RELCALL;
  assign is_indcall    = instr_word == OP_INDCALL;
  assign is_call       = (instr_word & OP_CALL_MASK) == OP_CALL;
  assign is_subexit    = instr_word == OP_SUBEXIT;
  assign is_intexit    = instr_word == OP_INTEXIT;
  assign is_eqskip     = (instr_word & OP_CMP_MASK) == OP_EQSKIP;
  assign is_regcmp     = (instr_word & OP_CMP_MASK) == OP_REGCMP;
  assign is_carrycmp   = (instr_word & OP_CMP_MASK) == OP_CARRYCMP;
  assign is_immcmp     = (instr_word & OP_IMMCMP_MASK) == OP_IMMCMP;
  assign is_regbit_clr = (instr_word & OP_REGBIT_MASK) == OP_REGBIT_CLR;
  assign is_regbit_set = (instr_word & OP_REGBIT_MASK) == OP_REGBIT_SET;
  assign is_iobit_clr  = (instr_word & OP_IOBIT_MASK) == OP_IOBIT_CLR;
  assign is_iobit_set  = (instr_word & OP_IOBIT_MASK) == OP_IOBIT_SET;
  assign is_flagbr_set = (instr_word & OP_FLAGBR_MASK) == OP_FLAGBR_SET;
  assign is_flagbr_clr = (instr_word & OP_FLAGBR_MASK) == OP_FLAGBR_CLR;
  assign is_cmp        = is_regcmp | is_carrycmp | is_immcmp;

  // Register selects: immediate compare reaches only the upper sixteen registers.
  always_comb
  begin
    if (is_immcmp)
    begin
      rd_sel = {1'b1, instr_word[7:4]};
    end
    else
    begin
      rd_sel = instr_word[8:4];
    end
    rr_sel  = {instr_word[9], instr_word[3:0]};
    io_addr = instr_word[7:3];
  end

  assign cmp_b = is_immcmp ? {instr_word[11:8], instr_word[3:0]} : rr_data;

  ccsb_cmp_flags ccsb_cmp_flags_i (
    .op_a      (rd_data),
    .op_b      (cmp_b),
    .use_carry (is_carrycmp),
    .carry_in  (flags_r[FLAG_C]),
    .zero_in   (flags_r[FLAG_Z]),
    .flag_h    (f_h),
    .flag_v    (f_v),
    .flag_n    (f_n),
    .flag_z    (f_z),
    .flag_c    (f_c)
  );

  assign rel12    = {{4{instr_word[11]}}, instr_word[11:0]};
  assign rel7     = {{9{instr_word[9]}}, instr_word[9:3]};
  assign pc_plus1 = pc_r + 16'h0001;
  assign pop_val  = stack_mem[sp_r - 4'h1];

  // Skip and branch conditions.
  always_comb
  begin
    skip_hit = 1'b0;
    br_hit   = 1'b0;
    if (is_eqskip)
    begin
      skip_hit = (rd_data == rr_data);
    end
    else if (is_regbit_clr)
    begin
      skip_hit = ~rd_data[instr_word[2:0]];
    end
    else if (is_regbit_set)
    begin
      skip_hit = rd_data[instr_word[2:0]];
    end
    else if (is_iobit_clr)
    begin
      skip_hit = ~io_data[instr_word[2:0]];
    end
    else if (is_iobit_set)
    begin
      skip_hit = io_data[instr_word[2:0]];
    end
    else if (is_flagbr_set)
    begin
      // Flag index 1 is Z, which makes this the branch on zero.
      br_hit = flags_r[instr_word[2:0]];
    end
    else if (is_flagbr_clr)
    begin
      br_hit = ~flags_r[instr_word[2:0]];
    end
  end

  // Target address, cycle count and stack traffic of the accepted instruction.
  always_comb
  begin
    target   = pc_plus1;
    cycles   = CYC_ONE;
    do_push  = 1'b0;
    push_val = pc_plus1;
    do_pop   = 1'b0;
    if (is_relcall)
    begin
      target  = pc_r + rel12 + 16'h0001;
      cycles  = CYC_RELCALL;
      do_push = 1'b1;
    end
    else if (is_indcall)
    begin
      target  = z_pointer;
      cycles  = CYC_INDCALL;
      do_push = 1'b1;
    end
    else if (is_call)
    begin
      target   = instr_ext;
      cycles   = CYC_CALL;
      do_push  = 1'b1;
      push_val = pc_r + 16'h0002;
    end
    else if (is_subexit | is_intexit)
    begin
      target = pop_val;
      cycles = CYC_EXIT;
      do_pop = 1'b1;
    end
    else if (skip_hit)
    begin
      target = next_is_two_word ? pc_r + 16'h0003 : pc_r + 16'h0002;
      cycles = next_is_two_word ? CYC_THREE : CYC_TWO;
    end
    else if (br_hit)
    begin
      target = pc_r + rel7 + 16'h0001;
      cycles = CYC_TWO;
    end
  end

  // Sequencer: one-cycle work retires at once, longer work waits out its count.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 3'd0;
      tgt_r   <= PC_RESET;
      pc_r    <= PC_RESET;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (accept)
          begin
            if (cycles == CYC_ONE)
            begin
              pc_r   <= target;
              done_r <= 1'b1;
            end
            else
            begin
              tgt_r   <= target;
              cnt_r   <= cycles - CYC_ONE;
              state_r <= ST_BUSY;
            end
          end
        end
        ST_BUSY:
        begin
          if (cnt_r == 3'd1)
          begin
            pc_r    <= tgt_r;
            done_r  <= 1'b1;
            state_r <= ST_IDLE;
          end
          cnt_r <= cnt_r - 3'd1;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Status flags: only compares and the interrupt return change them.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      flags_r <= FLAGS_RESET;
    end
    else if (accept && is_cmp)
    begin
      flags_r[FLAG_H] <= f_h;
      flags_r[FLAG_V] <= f_v;
      flags_r[FLAG_N] <= f_n;
      flags_r[FLAG_Z] <= f_z;
      flags_r[FLAG_C] <= f_c;
    end
    else if (accept && is_intexit)
    begin
      flags_r[FLAG_I] <= 1'b1;
    end
  end

  // Return stack: overflow wraps silently, so nesting beyond its depth is lost.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sp_r <= SP_RESET;
    end
    else if (accept && do_push)
    begin
      stack_mem[sp_r] <= push_val;
      sp_r            <= sp_r + 4'h1;
    end
    else if (accept && do_pop)
    begin
      sp_r <= sp_r - 4'h1;
    end
  end
endmodule
